// ---- design/fill_err_consts.svh ----
// Constants for the fill error syndrome and backup tag capture block.
// Assumes inclusion by the package and by every design file that needs them.
`ifndef FILL_ERR_CONSTS_SVH
`define FILL_ERR_CONSTS_SVH
`define SYN_W 14
`define LW_W 32
`define QW_W 64
`define CHK_W 7
`define TAG_W 16
`define TAG_FIELD_LSB 5
`define RD_W 16
`define SEL_FILL_SYN 2'h0
`define SEL_FILL_ADDR 2'h1
`define SEL_TAG 2'h2
`define SEL_FILL_STAT 2'h3
`define SYN_NONE 7'h00
`define SYN_BAD_SYS 7'h1F
`define PAR_LO_BIT 0
`define PAR_HI_BIT 7
`define STAT_EDC_BIT 0
`define STAT_PAR_BIT 1
`define STAT_IRD_BIT 2
`define STAT_QW_LSB 3
`define STAT_LOCK_BIT 5
`define RST_SYN 14'h0000
`define RST_TAG 16'h0000
`endif

// ---- design/fill_err_pkg.sv ----
// Types shared by the fill error block and its helpers.
// Assumes the constants header is on the include path.
`include "fill_err_consts.svh"
package fill_err_pkg;
    typedef logic [`CHK_W-1:0] syndrome_t;
    typedef logic [`TAG_W-1:0] tag_word_t;
    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_ANSWER = 2'b10
    } rd_state_t;

    // Syndrome produced by a single flipped data bit
    function automatic syndrome_t data_bit_code(input logic [4:0] idx);
        syndrome_t c;
        c = 7'h00;
        unique case (idx)
            5'h00: c = 7'h4F;
            5'h01: c = 7'h4A;
            5'h02: c = 7'h52;
            5'h03: c = 7'h54;
            5'h04: c = 7'h57;
            5'h05: c = 7'h58;
            5'h06: c = 7'h5B;
            5'h07: c = 7'h5D;
            5'h08: c = 7'h23;
            5'h09: c = 7'h25;
            5'h0A: c = 7'h26;
            5'h0B: c = 7'h29;
            5'h0C: c = 7'h2A;
            5'h0D: c = 7'h2C;
            5'h0E: c = 7'h31;
            5'h0F: c = 7'h34;
            5'h10: c = 7'h0E;
            5'h11: c = 7'h0B;
            5'h12: c = 7'h13;
            5'h13: c = 7'h15;
            5'h14: c = 7'h16;
            5'h15: c = 7'h19;
            5'h16: c = 7'h1A;
            5'h17: c = 7'h1C;
            5'h18: c = 7'h62;
            5'h19: c = 7'h64;
            5'h1A: c = 7'h67;
            5'h1B: c = 7'h68;
            5'h1C: c = 7'h6B;
            5'h1D: c = 7'h6D;
            5'h1E: c = 7'h70;
            5'h1F: c = 7'h75;
        endcase
        return c;
    endfunction : data_bit_code
endpackage : fill_err_pkg

// ---- design/edc_check_gen.sv ----
// Check bit generator for one longword.
// Assumes purely combinational use; the caller registers the result.
`timescale 1ns/10ps
module edc_check_gen
    import fill_err_pkg::*;
(
    // Data in
    input wire logic [`LW_W-1:0] data_i,
    // Check bits out
    output syndrome_t check_o
);
    // Each data bit folds its own column code in, so a flipped bit yields exactly that code
    always_comb begin
        check_o = 7'h00;
        for (int i = 0; i < `LW_W; i++) begin
            if (data_i[i]) begin
                check_o = check_o ^ data_bit_code(5'(i));
            end
        end
    end
endmodule : edc_check_gen

// ---- design/backup_tag_capture.sv ----
// Backup tag capture register with lock and serial read-out.
// Assumes the caller sequences reads, so shift pulses never run back to back.
`timescale 1ns/10ps
module backup_tag_capture
    import fill_err_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Probe side
    input wire logic probe_valid_i,
    input wire tag_word_t probe_tag_i,
    input wire tag_word_t mask_i,
    // Control
    input wire logic lock_req_i,
    input wire logic unlock_i,
    input wire logic shift_i,
    // State out
    output tag_word_t tag_o,
    output logic locked_o
);
    tag_word_t tag_r;
    tag_word_t tag_nxt;
    logic locked_r;
    logic locked_nxt;

    assign tag_nxt = shift_i ? (tag_r >> 1) :
                     (probe_valid_i && !locked_r) ? (probe_tag_i & mask_i) :
                     tag_r;
    // Lock beats a same-cycle unlock, so an error is never lost
    assign locked_nxt = lock_req_i ? 1'b1 : (unlock_i ? 1'b0 : locked_r);

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tag_r <= `RST_TAG;
            locked_r <= 1'b0;
        end else if (clk_en_i) begin
            tag_r <= tag_nxt;
            locked_r <= locked_nxt;
        end
    end

    assign tag_o = tag_r;
    assign locked_o = locked_r;
endmodule : backup_tag_capture

// ---- design/fill_error_syndrome_capture.sv ----
// Fill error syndrome capture and backup tag capture, top level.
// Assumes all inputs come from core logic on clk_sys_i; register access
// is by single-cycle processor register read and write strobes.
`timescale 1ns/10ps
module fill_error_syndrome_capture
    import fill_err_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Configuration from bus unit control
    input wire logic edc_mode_i,
    input wire logic [1:0] external_cache_size_field_i,
    // Fill path
    input wire logic fill_valid_i,
    input wire logic [`QW_W-1:0] fill_data_i,
    input wire logic [`SYN_W-1:0] fill_check_i,
    input wire logic [1:0] fill_quadword_index_i,
    input wire logic fill_last_i,
    input wire logic fill_icache_i,
    input wire logic fill_req_i,
    // Store path
    input wire logic store_valid_i,
    input wire logic [`QW_W-1:0] store_data_i,
    // Backup tag probe
    input wire logic probe_valid_i,
    input wire tag_word_t probe_tag_i,
    input wire logic tag_par_err_i,
    input wire logic tag_ctl_par_err_i,
    // Processor register access
    input wire logic processor_register_read_i,
    input wire logic processor_register_write_i,
    input wire logic [1:0] reg_sel_i,
    // Machine check handshake
    input wire logic mchk_ack_i,
    // Cache write
    output logic cache_wr_o,
    output logic cache_wr_icache_o,
    output logic cache_wr_valid_o,
    output logic [1:0] cache_wr_qw_o,
    output logic [`QW_W-1:0] cache_wr_data_o,
    output logic [`SYN_W-1:0] cache_wr_check_o,
    // Register file write
    output logic regfile_wr_o,
    output logic [`QW_W-1:0] regfile_data_o,
    // Store check bits
    output logic store_check_valid_o,
    output logic [`SYN_W-1:0] store_check_o,
    // Machine check
    output logic mchk_o,
    output logic exec_hold_o,
    // Register read answer
    output logic reg_rd_valid_o,
    output logic [`RD_W-1:0] reg_rd_data_o,
    // Status
    output logic syn_locked_o,
    output logic tag_locked_o,
    output logic syn_invalid_o,
    output logic [6:0] err_pos_lo_o,
    output logic [6:0] err_pos_hi_o
);
    // Decode a syndrome to {found, is_check, bit index}
    function automatic logic [6:0] locate_bit(input syndrome_t s);
        logic [6:0] r;
        r = 7'h00;
        for (int i = 0; i < `CHK_W; i++) begin
            if (s == syndrome_t'(7'h01 << i)) begin
                r = {2'b11, 5'(i)};
            end
        end
        for (int i = 0; i < `LW_W; i++) begin
            if (s == data_bit_code(5'(i))) begin
                r = {2'b10, 5'(i)};
            end
        end
        return r;
    endfunction : locate_bit

    syndrome_t gen_lo;
    syndrome_t gen_hi;
    syndrome_t st_lo;
    syndrome_t st_hi;
    syndrome_t syn_lo;
    syndrome_t syn_hi;
    logic par_bad_lo;
    logic par_bad_hi;
    logic edc_err;
    logic par_err;
    logic fill_err;
    logic syn_unlock;
    logic capture;
    logic [`SYN_W-1:0] syn_r;
    logic [`SYN_W-1:0] syn_nxt;
    logic syn_locked_r;
    logic syn_locked_nxt;
    logic stat_edc_r;
    logic stat_par_r;
    logic stat_ird_r;
    logic [1:0] stat_qw_r;
    logic hold_r;
    logic hold_nxt;
    rd_state_t rd_state_r;
    rd_state_t rd_state_nxt;
    logic [1:0] rd_sel_r;
    logic rd_take;
    logic rd_done;
    logic tag_shift;
    logic tag_unlock;
    logic tag_lock;
    tag_word_t tag_val;
    tag_word_t tag_mask;
    logic tag_locked;
    logic [`RD_W-1:0] rd_data_nxt;
    logic [`RD_W-1:0] stat_word;
    logic [4:0] unused_cnt;

    edc_check_gen u_gen_lo (.data_i(fill_data_i[`LW_W-1:0]), .check_o(gen_lo));
    edc_check_gen u_gen_hi (.data_i(fill_data_i[`QW_W-1:`LW_W]), .check_o(gen_hi));
    edc_check_gen u_st_lo (.data_i(store_data_i[`LW_W-1:0]), .check_o(st_lo));
    edc_check_gen u_st_hi (.data_i(store_data_i[`QW_W-1:`LW_W]), .check_o(st_hi));

    // Fill checking, one quadword per beat
    assign syn_lo = gen_lo ^ fill_check_i[`CHK_W-1:0];
    assign syn_hi = gen_hi ^ fill_check_i[`SYN_W-1:`CHK_W];
    assign par_bad_lo = (^fill_data_i[`LW_W-1:0]) ^ fill_check_i[`PAR_LO_BIT];
    assign par_bad_hi = (^fill_data_i[`QW_W-1:`LW_W]) ^ fill_check_i[`PAR_HI_BIT];
    assign edc_err = edc_mode_i && ((syn_lo != `SYN_NONE) || (syn_hi != `SYN_NONE));
    assign par_err = !edc_mode_i && (par_bad_lo || par_bad_hi);
    assign fill_err = fill_valid_i && (edc_err || par_err);

    // Capture while free; a read that frees the lock in the same cycle does not drop the error
    assign capture = fill_err && (!syn_locked_r || syn_unlock);
    assign syn_nxt = !capture ? syn_r :
                     edc_mode_i ? {syn_hi, syn_lo} :
                     {6'h00, par_bad_hi, 6'h00, par_bad_lo};
    assign syn_locked_nxt = capture ? 1'b1 : (syn_unlock ? 1'b0 : syn_locked_r);

    // Execution hold stays up until the vector is taken; a new EDC error wins over the ack
    assign hold_nxt = (fill_valid_i && edc_err) ? 1'b1 : (mchk_ack_i ? 1'b0 : hold_r);

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            syn_r <= `RST_SYN;
            syn_locked_r <= 1'b0;
            stat_edc_r <= 1'b0;
            stat_par_r <= 1'b0;
            stat_ird_r <= 1'b0;
            stat_qw_r <= 2'h0;
            hold_r <= 1'b0;
        end else if (clk_en_i) begin
            syn_r <= syn_nxt;
            syn_locked_r <= syn_locked_nxt;
            hold_r <= hold_nxt;
            if (capture) begin
                stat_edc_r <= edc_mode_i;
                stat_par_r <= !edc_mode_i;
                stat_ird_r <= fill_icache_i;
                stat_qw_r <= fill_quadword_index_i;
            end
        end
    end

    // Fill pass-through: block goes in unchanged and is validated even on error
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cache_wr_o <= 1'b0;
            cache_wr_icache_o <= 1'b0;
            cache_wr_valid_o <= 1'b0;
            cache_wr_qw_o <= 2'h0;
            cache_wr_data_o <= '0;
            cache_wr_check_o <= '0;
            regfile_wr_o <= 1'b0;
            regfile_data_o <= '0;
            mchk_o <= 1'b0;
        end else if (clk_en_i) begin
            cache_wr_o <= fill_valid_i;
            cache_wr_icache_o <= fill_icache_i;
            cache_wr_valid_o <= fill_valid_i && fill_last_i;
            cache_wr_qw_o <= fill_quadword_index_i;
            cache_wr_data_o <= fill_data_i;
            cache_wr_check_o <= fill_check_i;
            regfile_wr_o <= fill_valid_i && fill_req_i && !fill_icache_i;
            regfile_data_o <= fill_data_i;
            mchk_o <= fill_valid_i && edc_err;
        end
    end

    // Store check bit generation
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            store_check_valid_o <= 1'b0;
            store_check_o <= '0;
        end else if (clk_en_i) begin
            store_check_valid_o <= store_valid_i && edc_mode_i;
            store_check_o <= {st_hi, st_lo};
        end
    end

    // Register reads: a read is taken only from idle, which also spaces tag reads
    assign rd_take = processor_register_read_i && (rd_state_r == RD_IDLE);
    assign rd_done = (rd_state_r == RD_ANSWER);
    always_comb begin
        rd_state_nxt = rd_state_r;
        unique case (rd_state_r)
            RD_IDLE: begin
                if (rd_take) begin
                    rd_state_nxt = RD_ANSWER;
                end
            end
            RD_ANSWER: begin
                rd_state_nxt = RD_IDLE;
            end
            default: begin
                rd_state_nxt = RD_IDLE;
            end
        endcase
    end

    assign syn_unlock = rd_take && (reg_sel_i == `SEL_FILL_ADDR);
    assign tag_shift = rd_done && (rd_sel_r == `SEL_TAG);
    assign tag_unlock = processor_register_write_i && (reg_sel_i == `SEL_TAG);
    assign tag_lock = (probe_valid_i && (tag_par_err_i || tag_ctl_par_err_i)) || fill_err;
    assign unused_cnt = {2'b00, external_cache_size_field_i, 1'b0};
    // Larger caches leave the low tag field bits unused
    assign tag_mask = ~(((16'h0001 << unused_cnt) - 16'h0001) << `TAG_FIELD_LSB);

    backup_tag_capture u_tag (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .probe_valid_i(probe_valid_i),
        .probe_tag_i(probe_tag_i),
        .mask_i(tag_mask),
        .lock_req_i(tag_lock),
        .unlock_i(tag_unlock),
        .shift_i(tag_shift),
        .tag_o(tag_val),
        .locked_o(tag_locked)
    );

    assign stat_word = {10'h000, syn_locked_r, stat_qw_r, stat_ird_r, stat_par_r, stat_edc_r};
    assign rd_data_nxt = (rd_sel_r == `SEL_FILL_SYN) ? {2'b00, syn_r} :
                         (rd_sel_r == `SEL_TAG) ? {15'h0000, tag_val[0]} :
                         (rd_sel_r == `SEL_FILL_STAT) ? stat_word :
                         16'h0000;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_state_r <= RD_IDLE;
            rd_sel_r <= 2'h0;
            reg_rd_valid_o <= 1'b0;
            reg_rd_data_o <= '0;
        end else if (clk_en_i) begin
            rd_state_r <= rd_state_nxt;
            if (rd_take) begin
                rd_sel_r <= reg_sel_i;
            end
            reg_rd_valid_o <= rd_done;
            reg_rd_data_o <= rd_done ? rd_data_nxt : reg_rd_data_o;
        end
    end

    // Status outputs; the invalid flag and bit positions are decoded from the held syndrome
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            exec_hold_o <= 1'b0;
            syn_locked_o <= 1'b0;
            tag_locked_o <= 1'b0;
            syn_invalid_o <= 1'b0;
            err_pos_lo_o <= 7'h00;
            err_pos_hi_o <= 7'h00;
        end else if (clk_en_i) begin
            exec_hold_o <= hold_nxt;
            syn_locked_o <= syn_locked_nxt;
            tag_locked_o <= tag_locked;
            syn_invalid_o <= stat_edc_r && ((syn_r[6:0] == `SYN_BAD_SYS)
                             || (syn_r[13:7] == `SYN_BAD_SYS));
            err_pos_lo_o <= stat_edc_r ? locate_bit(syn_r[6:0]) : 7'h00;
            err_pos_hi_o <= stat_edc_r ? locate_bit(syn_r[13:7]) : 7'h00;
        end
    end

    // Checks assume clk_en_i stays high across each window
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    a_syn_lock_hold: assert property (syn_locked_r && !syn_unlock && clk_en_i |=> $stable(syn_r))
        else $error("locked syndrome changed");
    a_syn_edc_capture: assert property (clk_en_i && capture && edc_mode_i |=>
        syn_r == $past({syn_hi, syn_lo}) && syn_locked_r)
        else $error("EDC syndrome not captured");
    a_syn_clean_fill: assert property (clk_en_i && fill_valid_i && edc_mode_i && syn_lo == 7'h00
        && syn_hi == 7'h00 && !syn_locked_r |=> !syn_locked_r)
        else $error("clean fill locked syndrome");
    a_parity_raz: assert property (stat_par_r && syn_locked_r |-> syn_r[13:8] == 6'h00 && syn_r[6:1] == 6'h00)
        else $error("parity syndrome high bits nonzero");
    a_mchk_post: assert property (clk_en_i && fill_valid_i && edc_err |=>
        mchk_o && exec_hold_o && cache_wr_o)
        else $error("machine check not posted");
    a_hold_load: assert property (regfile_wr_o && mchk_o |-> exec_hold_o)
        else $error("issue not held with load result");
    a_tag_shift_one: assert property (clk_en_i && tag_shift |=> tag_val == ($past(tag_val) >> 1))
        else $error("tag did not shift by one");
    a_tag_lock_keep: assert property (clk_en_i && tag_locked && !tag_shift && !tag_unlock |=>
        $stable(tag_val) && tag_locked)
        else $error("locked tag changed");
    a_read_spacing: assert property (reg_rd_valid_o |=> !reg_rd_valid_o)
        else $error("reads answered back to back");
    a_par_capture: assert property (clk_en_i && capture && !edc_mode_i |=>
        syn_r == {6'h00, $past(par_bad_hi), 6'h00, $past(par_bad_lo)})
        else $error("parity flags not captured");
    a_addr_unlock: assert property (clk_en_i && syn_unlock && !fill_err |=> !syn_locked_r)
        else $error("lock kept after address read");
    a_tag_probe_load: assert property (clk_en_i && probe_valid_i && !tag_locked && !tag_shift |=>
        tag_val == ($past(probe_tag_i) & $past(tag_mask)))
        else $error("probe tag not loaded");
    a_fill_lock_tag: assert property (clk_en_i && fill_err |=> tag_locked)
        else $error("fill error left tag unlocked");
    a_hold_ack: assert property (clk_en_i && mchk_ack_i && !(fill_valid_i && edc_err) |=> !exec_hold_o)
        else $error("hold kept after ack");
endmodule : fill_error_syndrome_capture

// ---- dv/cache_fill_model.sv ----
// Far side model: system fill path and backup cache tag probes.
// Assumes one bench process calls its tasks, starting after reset.
`timescale 1ns/10ps
module cache_fill_model
    import fill_err_pkg::*;
(
    // Clock
    input wire logic clk_sys_i,
    // Fill beat
    output logic fill_valid_o,
    output logic [`QW_W-1:0] fill_data_o,
    output logic [`SYN_W-1:0] fill_check_o,
    output logic [1:0] fill_quadword_index_o,
    output logic fill_last_o,
    output logic fill_icache_o,
    output logic fill_req_o,
    // Tag probe
    output logic probe_valid_o,
    output tag_word_t probe_tag_o,
    output logic tag_par_err_o,
    output logic tag_ctl_par_err_o
);
    initial begin
        {fill_valid_o, fill_last_o, fill_icache_o, fill_req_o} = 4'h0;
        {probe_valid_o, tag_par_err_o, tag_ctl_par_err_o} = 3'h0;
        fill_data_o = 64'h0000_0000_0000_0000;
        fill_check_o = 14'h0000;
        fill_quadword_index_o = 2'h0;
        probe_tag_o = 16'h0000;
    end

    task automatic beat(input logic [63:0] d, input logic [13:0] c, input logic [1:0] qw, input logic ic,
                        input logic rq);
        @(posedge clk_sys_i);
        {fill_valid_o, fill_last_o, fill_icache_o, fill_req_o} <= {2'h3, ic, rq};
        fill_data_o <= d;
        fill_check_o <= c;
        fill_quadword_index_o <= qw;
        @(posedge clk_sys_i);
        {fill_valid_o, fill_last_o} <= 2'h0;
        // Released lines show the inverse, never a stale copy
        fill_data_o <= ~d;
        fill_check_o <= ~c;
    endtask : beat

    task automatic probe(input logic [15:0] t, input logic pe, input logic ce);
        @(posedge clk_sys_i);
        {probe_valid_o, tag_par_err_o, tag_ctl_par_err_o} <= {1'h1, pe, ce};
        probe_tag_o <= t;
        @(posedge clk_sys_i);
        {probe_valid_o, tag_par_err_o, tag_ctl_par_err_o} <= 3'h0;
        probe_tag_o <= ~t;
    endtask : probe
endmodule : cache_fill_model

// ---- dv/fill_error_syndrome_capture_tb.sv ----
// Self-checking bench for the fill error syndrome and tag capture block.
// Assumes a zero-data longword has zero check bits.
`timescale 1ns/10ps
module fill_error_syndrome_capture_tb
    import fill_err_pkg::*;
;
    logic clk_sys_i, reset_n_i, clk_en_i, edc_mode_i, store_valid_i, mchk_ack_i;
    logic processor_register_read_i, processor_register_write_i;
    logic [1:0] external_cache_size_field_i, reg_sel_i, fill_quadword_index_i, cache_wr_qw_o;
    logic [63:0] store_data_i, fill_data_i, cache_wr_data_o, wr_data, regfile_data_o, rf_data;
    logic fill_valid_i, fill_last_i, fill_icache_i, fill_req_i, probe_valid_i, tag_par_err_i, tag_ctl_par_err_i;
    logic [13:0] fill_check_i, store_check_o, st_chk, cache_wr_check_o;
    tag_word_t probe_tag_i;
    logic cache_wr_o, cache_wr_valid_o, regfile_wr_o, store_check_valid_o, mchk_o, exec_hold_o, cache_wr_icache_o;
    logic [16:0] wr_meta;
    logic reg_rd_valid_o, syn_locked_o, tag_locked_o, syn_invalid_o;
    logic [15:0] reg_rd_data_o, d;
    logic [6:0] err_pos_lo_o, err_pos_hi_o;
    int n_fail = 0, tests_run = 0, n_mchk = 0, n_val = 0, n_rf = 0;

    fill_error_syndrome_capture fill_error_syndrome_capture_inst (
        .clk_sys_i, .reset_n_i, .clk_en_i, .edc_mode_i, .external_cache_size_field_i,
        .fill_valid_i, .fill_data_i, .fill_check_i, .fill_quadword_index_i, .fill_last_i, .fill_icache_i,
        .fill_req_i, .store_valid_i, .store_data_i, .probe_valid_i, .probe_tag_i, .tag_par_err_i,
        .tag_ctl_par_err_i, .processor_register_read_i, .processor_register_write_i, .reg_sel_i, .mchk_ack_i,
        .cache_wr_o, .cache_wr_icache_o, .cache_wr_valid_o, .cache_wr_qw_o, .cache_wr_data_o,
        .cache_wr_check_o, .regfile_wr_o, .regfile_data_o, .store_check_valid_o, .store_check_o, .mchk_o,
        .exec_hold_o, .reg_rd_valid_o, .reg_rd_data_o, .syn_locked_o, .tag_locked_o, .syn_invalid_o,
        .err_pos_lo_o, .err_pos_hi_o);

    cache_fill_model cache_fill_model_inst (
        .clk_sys_i, .fill_valid_o(fill_valid_i), .fill_data_o(fill_data_i), .fill_check_o(fill_check_i),
        .fill_quadword_index_o(fill_quadword_index_i), .fill_last_o(fill_last_i), .fill_icache_o(fill_icache_i),
        .fill_req_o(fill_req_i), .probe_valid_o(probe_valid_i), .probe_tag_o(probe_tag_i),
        .tag_par_err_o(tag_par_err_i), .tag_ctl_par_err_o(tag_ctl_par_err_i));

    always #25 clk_sys_i = ~clk_sys_i;

    // Pulses last one cycle, so count them as they pass
    always @(posedge clk_sys_i) begin
        if (mchk_o === 1'h1) n_mchk++;
        if (cache_wr_valid_o === 1'h1) n_val++;
        if (regfile_wr_o === 1'h1) n_rf++;
        if (cache_wr_o === 1'h1) wr_data = cache_wr_data_o;
        if (cache_wr_o === 1'h1) wr_meta = {cache_wr_icache_o, cache_wr_qw_o, cache_wr_check_o};
        if (regfile_wr_o === 1'h1) rf_data = regfile_data_o;
        if (store_check_valid_o === 1'h1) st_chk = store_check_o;
    end

    task automatic check_val(input logic [63:0] got, input logic [63:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check_val

    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // Reads are spaced by several cycles, well past the null cycle
    task automatic reg_read(input logic [1:0] s, output logic [15:0] v);
        v = 16'hxxxx;
        @(posedge clk_sys_i);
        processor_register_read_i <= 1'h1;
        reg_sel_i <= s;
        @(posedge clk_sys_i);
        processor_register_read_i <= 1'h0;
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys_i);
            #1;
            if (reg_rd_valid_o === 1'h1) begin
                v = reg_rd_data_o;
                break;
            end
        end
    endtask : reg_read

    task automatic tag_write();
        @(posedge clk_sys_i);
        processor_register_write_i <= 1'h1;
        reg_sel_i <= 2'h2;
        @(posedge clk_sys_i);
        processor_register_write_i <= 1'h0;
    endtask : tag_write

    task automatic read_tag(input logic [15:0] exp);
        logic [15:0] w, v;
        for (int i = 0; i < 16; i++) begin
            reg_read(2'h2, v);
            w[i] = v[0];
        end
        check_val(w, exp, "serial tag");
    endtask : read_tag

    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask : settle

    task automatic t_tag();
        @(posedge clk_sys_i);
        external_cache_size_field_i <= 2'h0;
        cache_fill_model_inst.probe(16'h1234, 1'h0, 1'h0);
        cache_fill_model_inst.probe(16'hABCD, 1'h0, 1'h0);
        read_tag(16'hABCD);
        @(posedge clk_sys_i);
        external_cache_size_field_i <= 2'h3;
        cache_fill_model_inst.probe(16'hFFFF, 1'h1, 1'h0);
        cache_fill_model_inst.probe(16'h0000, 1'h0, 1'h0);
        read_tag(16'hF81F);
        check_val(tag_locked_o, 1'h1, "tag lock");
        tag_write();
        external_cache_size_field_i <= 2'h1;
        cache_fill_model_inst.probe(16'h5A5A, 1'h0, 1'h0);
        read_tag(16'h5A1A);
        cache_fill_model_inst.probe(16'h0F0F, 1'h0, 1'h1);
        settle();
        check_val(tag_locked_o, 1'h1, "ctl lock");
        tag_write();
    endtask : t_tag

    task automatic t_edc();
        cache_fill_model_inst.beat(64'h8000_0000_0000_0001, 14'h0000, 2'h2, 1'h0, 1'h1);
        settle();
        check_val(n_mchk, 1, "mchk");
        check_val(wr_data, 64'h8000_0000_0000_0001, "fill data");
        check_val(wr_meta, 17'h0_8000, "fill copy");
        check_val(rf_data, 64'h8000_0000_0000_0001, "load data");
        check_val(n_val, 1, "validate");
        check_val(n_rf, 1, "load write");
        check_val(exec_hold_o, 1'h1, "hold");
        check_val({err_pos_hi_o, err_pos_lo_o}, 14'h2FC0, "decode");
        check_val(tag_locked_o, 1'h1, "fill tag lock");
        reg_read(2'h0, d);
        check_val(d, 16'h3ACF, "syndrome");
        reg_read(2'h3, d);
        check_val(d, 16'h0031, "status");
        @(posedge clk_sys_i);
        mchk_ack_i <= 1'h1;
        @(posedge clk_sys_i);
        mchk_ack_i <= 1'h0;
        settle();
        check_val(exec_hold_o, 1'h0, "hold release");
    endtask : t_edc

    task automatic t_relock();
        cache_fill_model_inst.beat(64'h0000_0000_0000_0000, 14'h0001, 2'h1, 1'h0, 1'h0);
        reg_read(2'h0, d);
        check_val(d, 16'h3ACF, "held syndrome");
        reg_read(2'h1, d);
        check_val(syn_locked_o, 1'h0, "unlock");
        cache_fill_model_inst.beat(64'h0000_0000_0000_0000, 14'h0040, 2'h3, 1'h1, 1'h0);
        settle();
        check_val({err_pos_hi_o, err_pos_lo_o}, 14'h0066, "check bit decode");
        check_val(n_mchk, 3, "icache mchk");
        check_val(wr_meta, 17'h1_C040, "icache copy");
        reg_read(2'h0, d);
        check_val(d, 16'h0040, "new syndrome");
        reg_read(2'h3, d);
        check_val(d, 16'h003D, "icache status");
        reg_read(2'h1, d);
        cache_fill_model_inst.beat(64'h0000_0000_0000_0000, 14'h001F, 2'h0, 1'h0, 1'h0);
        settle();
        check_val(syn_invalid_o, 1'h1, "poison");
        reg_read(2'h1, d);
    endtask : t_relock

    task automatic t_parity();
        @(posedge clk_sys_i);
        edc_mode_i <= 1'h0;
        cache_fill_model_inst.beat(64'h0000_0000_0000_0001, 14'h0000, 2'h0, 1'h0, 1'h0);
        reg_read(2'h0, d);
        check_val(d, 16'h0001, "low parity");
        reg_read(2'h1, d);
        cache_fill_model_inst.beat(64'h0000_0001_0000_0001, 14'h0000, 2'h0, 1'h0, 1'h0);
        reg_read(2'h0, d);
        check_val(d, 16'h0081, "both parity");
        check_val(n_mchk, 4, "no parity mchk");
        reg_read(2'h1, d);
        @(posedge clk_sys_i);
        edc_mode_i <= 1'h1;
        @(posedge clk_sys_i);
        {store_valid_i, store_data_i} <= {1'h1, 64'h0000_0001_0000_0001};
        @(posedge clk_sys_i);
        store_valid_i <= 1'h0;
        settle();
        check_val(st_chk, 14'h27CF, "store check");
    endtask : t_parity

    task automatic t_freeze();
        @(posedge clk_sys_i);
        clk_en_i <= 1'h0;
        cache_fill_model_inst.probe(16'h0F0F, 1'h1, 1'h0);
        settle();
        check_val(tag_locked_o, 1'h0, "frozen lock");
        @(posedge clk_sys_i);
        clk_en_i <= 1'h1;
    endtask : t_freeze

    initial begin
        {clk_sys_i, reset_n_i, store_valid_i, mchk_ack_i} = 4'h0;
        clk_en_i = 1'h1;
        {processor_register_read_i, processor_register_write_i, edc_mode_i} = 3'h1;
        {external_cache_size_field_i, reg_sel_i} = 4'h0;
        store_data_i = 64'h0000_0000_0000_0000;
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'h1;
        reg_read(2'h0, d);
        check_val(d, 16'h0000, "reset syndrome");
        t_tag();
        t_freeze();
        t_edc();
        t_relock();
        t_parity();
        stop_test();
    end

    initial begin
        #(50 * 20000);
        n_fail++;
        stop_test();
    end
endmodule : fill_error_syndrome_capture_tb
